// ---- shared/adc_seq_cfg.svh ----
// constants of the conversion sequencer: offsets, fields, reset values, timing
// assumes inclusion by bare name from design, checker and testbench files
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// register byte offsets on the apb bus
`define A_FUNC      8'h00
`define A_CFG       8'h04
`define A_CTRL      8'h08
`define A_STBY      8'h0C
`define A_BURN      8'h10
`define A_DAC       8'h14
`define A_ALERT     8'h18
`define A_MASK      8'h1C
`define A_LIVE      8'h20
`define A_RES1      8'h24
`define A_RES_LAST  8'h38

// converter configuration fields
`define CFG_W       23
`define C1_MUX_LSB  0
`define C1_RATE_LSB 4
`define C1_RNG_LSB  8
`define C2_MUX_LSB  12
`define C2_RATE_LSB 16
`define C2_RNG_LSB  20

// conversion control fields
`define CTRL_W       14
`define CC_EN_LSB    0
`define CC_MODE_LSB  8
`define CC_DRATE_LSB 12

// reset values
`define CFG_RST   23'h000000
`define CTRL_RST  14'h0000
`define STBY_RST  4'h0
`define BURN_RST  10'h000
`define DAC_RST   14'h0000
`define MASK_RST  1'h0

// channel functions and first conversion input codes
`define FN_HIZ       4'h0
`define FN_V_OUT     4'h1
`define FN_I_OUT     4'h2
`define FN_V_IN      4'h3
`define FN_I_IN_EXT  4'h4
`define FN_I_IN_LOOP 4'h5
`define MUX_TERM_V    4'h0
`define MUX_SENSE_RES 4'h1

// conversion rate codes
`define RATE_10   3'h0
`define RATE_20   3'h1
`define RATE_1K2  3'h2
`define RATE_4K8  3'h3
`define RATE_9K6  3'h4

// result codes and slot bookkeeping
`define CODE_FULL  16'hFFFF
`define CODE_ZERO  16'h0000
`define NO_SLOT    3'h6
`define NUM_SLOTS  6

// timing: clock period and conversion / ready-hold times in ns
`define CLK_NS      5
`define T_10_NS     100000000
`define T_20_NS     50000000
`define T_1K2_NS    833333
`define T_4K8_NS    208333
`define T_9K6_NS    104167
`define T_RDY_NS    24000
`define CYC_10      (`T_10_NS / `CLK_NS)
`define CYC_20      (`T_20_NS / `CLK_NS)
`define CYC_1K2     (`T_1K2_NS / `CLK_NS)
`define CYC_4K8     (`T_4K8_NS / `CLK_NS)
`define CYC_9K6     (`T_9K6_NS / `CLK_NS)
`define CYC_RDY     ((`T_RDY_NS + `CLK_NS - 1) / `CLK_NS)
`define TMR_W       25
`define RDY_W       13

`endif

// ---- shared/adc_seq_pkg.sv ----
// types of the conversion sequencer
// assumes adc_seq_cfg.svh for numeric constants
package adc_seq_pkg;
   typedef enum logic [1:0] {
      MODE_IDLE   = 2'b00,
      MODE_SINGLE = 2'b01,
      MODE_CONT   = 2'b10,
      MODE_PDOWN  = 2'b11
   } seq_mode_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONV = 2'b01,
      ST_DONE = 2'b10
   } seq_state_e;
endpackage

// ---- rtl/conv_timer.sv ----
// conversion timer: times one conversion from the on-chip oscillator (pclk)
// assumes start is a one-cycle pulse and rate is valid with it
`timescale 1ns/1ps
module conv_timer #(
   parameter int CW = 25,
   parameter logic [CW-1:0] C10  = '1,
   parameter logic [CW-1:0] C20  = '1,
   parameter logic [CW-1:0] C1K2 = '1,
   parameter logic [CW-1:0] C4K8 = '1,
   parameter logic [CW-1:0] C9K6 = '1
)(
   // clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // request
   input  wire logic         start,
   input  wire logic [2:0]   rate,
   // result
   output logic              done
);
   logic [CW-1:0] cnt_r;
   logic          busy_r;
   logic [CW-1:0] load_val;

   // rate code to cycle count; undefined codes fall back to the fastest rate
   assign load_val = (rate == 3'h0) ? C10 - 1'b1 :
                     (rate == 3'h1) ? C20 - 1'b1 :
                     (rate == 3'h2) ? C1K2 - 1'b1 :
                     (rate == 3'h3) ? C4K8 - 1'b1 : C9K6 - 1'b1;

   // down counter, done is registered and pulses the cycle after the count reaches zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r  <= '0;
         busy_r <= 1'b0;
         done   <= 1'b0;
      end else begin
         done <= busy_r && cnt_r == '0;
         if (start) begin
            cnt_r  <= load_val;
            busy_r <= 1'b1;
         end else if (busy_r && cnt_r == '0) begin
            busy_r <= 1'b0;
         end else if (busy_r) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule

// ---- rtl/result_bank.sv ----
// result bank: shadow words filled during a sequence, visible words for reads
// assumes commit is a one-cycle pulse at sequence end
`timescale 1ns/1ps
module result_bank #(
   parameter int W = 16,
   parameter int N = 6
)(
   // clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // shadow write
   input  wire logic                 wr_en,
   input  wire logic [2:0]           wr_idx,
   input  wire logic [W-1:0]         wr_data,
   // publish shadow to visible
   input  wire logic                 commit,
   // registered read port
   input  wire logic [2:0]           rd_idx,
   output logic      [W-1:0]         rd_data
);
   logic [W-1:0] shadow_r [N];
   logic [W-1:0] visible_r [N];

   // visible words only change at commit, so reads mid-sequence stay coherent
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < N; i++) begin
            shadow_r[i]  <= '0;
            visible_r[i] <= '0;
         end
         rd_data <= '0;
      end else begin
         if (wr_en && int'(wr_idx) < N)
            shadow_r[wr_idx] <= wr_data;
         if (commit)
            for (int i = 0; i < N; i++) visible_r[i] <= shadow_r[i];
         rd_data <= (int'(rd_idx) < N) ? visible_r[rd_idx] : '0;
      end
   end
endmodule

// ---- rtl/adc_conversion_sequencer.sv ----
// conversion sequencer for one shared 16-bit converter with apb registers
// assumes converter code and range flags arrive on pclk when a conversion
// ends; the analog front end and dac slewing live outside
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"

module adc_conversion_sequencer #(
   parameter int unsigned CYC_10  = `CYC_10,
   parameter int unsigned CYC_20  = `CYC_20,
   parameter int unsigned CYC_1K2 = `CYC_1K2,
   parameter int unsigned CYC_4K8 = `CYC_4K8,
   parameter int unsigned CYC_9K6 = `CYC_9K6,
   parameter int unsigned CYC_RDY = `CYC_RDY
)(
   // clock and reset
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   // apb slave
   input  wire logic [7:0]                paddr,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   // converter result
   input  wire logic [15:0]               adc_code,
   input  wire logic                      adc_over,
   input  wire logic                      adc_under,
   // converter steering
   output logic      [2:0]                conv_slot,
   output logic      [3:0]                conv_mux,
   output logic      [2:0]                conv_range,
   output logic      [2:0]                conv_rate,
   output logic                           mains_reject,
   output logic                           conv_active,
   output logic                           adc_powerdown,
   // sense buffers and burnout
   output logic      [3:0]                buffer_standby,
   output logic                           aux_one_burnout_enable,
   output logic                           aux_one_burnout_polarity,
   output logic      [2:0]                aux_one_burnout_level,
   output logic                           aux_two_burnout_enable,
   output logic                           aux_two_burnout_polarity,
   output logic      [2:0]                aux_two_burnout_level,
   // dac code and pins
   output logic      [13:0]               dac_code,
   output logic                           adc_rdy_n,
   output logic                           alert_n
);
   import adc_seq_pkg::*;

   // registers
   logic [3:0]              func_r;
   logic [`CFG_W-1:0]       cfg_r;
   logic [`CTRL_W-1:0]      ctrl_r;
   logic [3:0]              stby_r;
   logic [9:0]              burn_r;
   logic [13:0]             dac_r;
   logic                    err_r;
   logic                    mask_r;
   logic                    drdy_r;
   logic [`RDY_W-1:0]       rdy_cnt_r;
   logic [2:0]              slot_r;
   seq_state_e              state_r;
   seq_state_e              state_nxt;
   logic                    ld;
   logic [2:0]              ld_idx;

   // conversion slot helpers
   function automatic logic [2:0] next_slot(input logic [5:0] en, input logic [2:0] from);
      logic [2:0] r;
      r = `NO_SLOT;
      for (int i = `NUM_SLOTS - 1; i >= 0; i--)
         if (en[i] && 3'(i) >= from) r = 3'(i);
      return r;
   endfunction

   // channel function to first conversion input default
   function automatic logic [3:0] func_default(input logic [3:0] f);
      logic [3:0] m;
      case (f)
         `FN_I_OUT, `FN_I_IN_EXT, `FN_I_IN_LOOP: m = `MUX_SENSE_RES;
         default: m = `MUX_TERM_V;
      endcase
      return m;
   endfunction

   // field views
   wire [5:0]  slot_en   = ctrl_r[`CC_EN_LSB +: 6];
   wire [1:0]  mode_bits = ctrl_r[`CC_MODE_LSB +: 2];
   wire [1:0]  drate     = ctrl_r[`CC_DRATE_LSB +: 2];
   wire [3:0]  c1_mux    = cfg_r[`C1_MUX_LSB +: 4];
   wire [2:0]  c1_rate   = cfg_r[`C1_RATE_LSB +: 3];
   wire [2:0]  c1_rng    = cfg_r[`C1_RNG_LSB +: 3];
   wire [3:0]  c2_mux    = cfg_r[`C2_MUX_LSB +: 4];
   wire [2:0]  c2_rate   = cfg_r[`C2_RATE_LSB +: 3];
   wire [2:0]  c2_rng    = cfg_r[`C2_RNG_LSB +: 3];
   wire        is_single = mode_bits == MODE_SINGLE;
   wire        is_cont   = mode_bits == MODE_CONT;

   // diagnostics share one rate: 20 SPS, 4.8 kSPS or 9.6 kSPS
   wire [2:0]  diag_rate = (drate == 2'h0) ? `RATE_20 :
                           (drate == 2'h1) ? `RATE_4K8 : `RATE_9K6;

   // settings of the slot about to be loaded, each channel with its own
   wire [2:0]  ld_rate   = (ld_idx == 3'h0) ? c1_rate :
                           (ld_idx == 3'h1) ? c2_rate : diag_rate;
   wire [2:0]  ld_rng    = (ld_idx == 3'h0) ? c1_rng :
                           (ld_idx == 3'h1) ? c2_rng : 3'h0;
   wire [3:0]  ld_mux    = (ld_idx == 3'h0) ? c1_mux :
                           (ld_idx == 3'h1) ? c2_mux : 4'h0;

   // apb decode; one wait state lets the result bank register its read
   wire        acc       = psel & penable;
   wire        rd_phase  = acc & ~pready;
   wire        wr_en     = acc & pready & pwrite;
   wire        sel_func  = paddr == `A_FUNC;
   wire        sel_cfg   = paddr == `A_CFG;
   wire        sel_ctrl  = paddr == `A_CTRL;
   wire        sel_stby  = paddr == `A_STBY;
   wire        sel_burn  = paddr == `A_BURN;
   wire        sel_dac   = paddr == `A_DAC;
   wire        sel_alert = paddr == `A_ALERT;
   wire        sel_mask  = paddr == `A_MASK;
   wire        sel_live  = paddr == `A_LIVE;
   wire        sel_res   = paddr >= `A_RES1 && paddr <= `A_RES_LAST && paddr[1:0] == 2'h0;
   wire        hit       = sel_func | sel_cfg | sel_ctrl | sel_stby | sel_burn | sel_dac |
                           sel_alert | sel_mask | sel_live | sel_res;
   wire [7:0]  res_off   = paddr - `A_RES1;
   wire [2:0]  res_idx   = res_off[4:2];
   wire        wr_ok     = wr_en & hit;

   // sequencing
   wire [2:0]  first_slot = next_slot(slot_en, 3'h0);
   wire [2:0]  after_slot = next_slot(slot_en, slot_r + 3'h1);
   wire        run_req    = (is_single | is_cont) && first_slot != `NO_SLOT;
   wire        tmr_done;
   wire        conv_end   = state_r == ST_CONV && tmr_done;
   wire        done_evt   = state_r == ST_DONE;

   // saturated result of the conversion just ended
   wire        range_bad = adc_over | adc_under;
   wire [15:0] sat_code  = adc_over  ? `CODE_FULL :
                           adc_under ? `CODE_ZERO : adc_code;
   wire [15:0] bank_rd;

   // ready release paths; completing a sequence wins over all of them
   wire        ctrl_wr   = wr_ok & sel_ctrl;
   wire        drdy_clr  = wr_ok & sel_live & pwdata[0];
   wire        rdy_tmo   = is_cont && !adc_rdy_n && rdy_cnt_r == `RDY_W'(CYC_RDY - 1);

   // read mux
   wire [31:0] rd_mux = sel_func  ? {28'h0, func_r} :
                        sel_cfg   ? {9'h0, cfg_r} :
                        sel_ctrl  ? {18'h0, ctrl_r} :
                        sel_stby  ? {28'h0, stby_r} :
                        sel_burn  ? {22'h0, burn_r} :
                        sel_dac   ? {18'h0, dac_r} :
                        sel_alert ? {31'h0, err_r} :
                        sel_mask  ? {31'h0, mask_r} :
                        sel_live  ? {30'h0, conv_active, drdy_r} :
                        sel_res   ? {16'h0, bank_rd} : 32'h0;

   // sequencer next state: slots run in order, stop is only seen at the end
   always_comb begin
      state_nxt = state_r;
      ld        = 1'b0;
      ld_idx    = first_slot;
      case (state_r)
         ST_IDLE: begin
            if (run_req) begin
               ld        = 1'b1;
               state_nxt = ST_CONV;
            end
         end
         ST_CONV: begin
            if (tmr_done) begin
               if (after_slot == `NO_SLOT) begin
                  state_nxt = ST_DONE;
               end else begin
                  ld     = 1'b1;
                  ld_idx = after_slot;
               end
            end
         end
         ST_DONE: begin
            if (is_cont && run_req) begin
               ld        = 1'b1;
               state_nxt = ST_CONV;
            end else begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   // state and slot steering
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r      <= ST_IDLE;
         slot_r       <= 3'h0;
         conv_mux     <= 4'h0;
         conv_range   <= 3'h0;
         conv_rate    <= 3'h0;
         mains_reject <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (ld) begin
            slot_r       <= ld_idx;
            conv_mux     <= ld_mux;
            conv_range   <= ld_rng;
            conv_rate    <= ld_rate;
            mains_reject <= ld_rate <= `RATE_20;
         end
      end
   end

   // activity outputs track the next state so they line up with the slot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_slot     <= 3'h0;
         conv_active   <= 1'b0;
         adc_powerdown <= 1'b0;
      end else begin
         conv_slot     <= ld ? ld_idx : conv_slot;
         conv_active   <= state_nxt != ST_IDLE;
         adc_powerdown <= state_nxt == ST_IDLE && mode_bits == MODE_PDOWN;
      end
   end

   // configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         func_r <= 4'h0;
         cfg_r  <= `CFG_RST;
         stby_r <= `STBY_RST;
         burn_r <= `BURN_RST;
         dac_r  <= `DAC_RST;
         mask_r <= `MASK_RST;
      end else begin
         if (wr_ok && sel_func) begin
            func_r <= pwdata[3:0];
            cfg_r[`C1_MUX_LSB +: 4] <= func_default(pwdata[3:0]);
         end else if (wr_ok && sel_cfg) begin
            cfg_r <= pwdata[`CFG_W-1:0];
         end
         if (wr_ok && sel_stby)
            stby_r <= pwdata[3:0];
         if (wr_ok && sel_burn)
            burn_r <= pwdata[9:0];
         // the dac code is only ever written here, never by a function change
         if (wr_ok && sel_dac)
            dac_r <= pwdata[13:0];
         if (wr_ok && sel_mask)
            mask_r <= pwdata[0];
      end
   end

   // control register; a finished single sequence falls back to idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= `CTRL_RST;
      end else if (ctrl_wr) begin
         ctrl_r <= pwdata[`CTRL_W-1:0];
      end else if (done_evt && is_single) begin
         ctrl_r[`CC_MODE_LSB +: 2] <= MODE_IDLE;
      end
   end

   // sticky flags: a hardware set wins over a write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_r   <= 1'b0;
         drdy_r  <= 1'b0;
         alert_n <= 1'b1;
      end else begin
         if (conv_end && range_bad)
            err_r <= 1'b1;
         else if (wr_ok && sel_alert && pwdata[0])
            err_r <= 1'b0;
         if (done_evt)
            drdy_r <= 1'b1;
         else if (drdy_clr)
            drdy_r <= 1'b0;
         alert_n <= ~(err_r & ~mask_r);
      end
   end

   // ready pin: falls on the same edge as the results commit, released three ways
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_rdy_n <= 1'b1;
         rdy_cnt_r <= '0;
      end else begin
         if (done_evt) begin
            adc_rdy_n <= 1'b0;
            rdy_cnt_r <= '0;
         end else if (ctrl_wr || drdy_clr || rdy_tmo) begin
            adc_rdy_n <= 1'b1;
            rdy_cnt_r <= '0;
         end else if (!adc_rdy_n && is_cont) begin
            rdy_cnt_r <= rdy_cnt_r + 1'b1;
         end
      end
   end

   // apb answer, one wait state; unmapped addresses answer with pslverr
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= rd_phase;
         pslverr <= rd_phase & ~hit;
         if (rd_phase)
            prdata <= pwrite ? 32'h0 : rd_mux;
      end
   end

   // plain copies of held settings
   assign buffer_standby           = stby_r;
   assign aux_one_burnout_enable   = burn_r[0];
   assign aux_one_burnout_polarity = burn_r[1];
   assign aux_one_burnout_level    = burn_r[4:2];
   assign aux_two_burnout_enable   = burn_r[5];
   assign aux_two_burnout_polarity = burn_r[6];
   assign aux_two_burnout_level    = burn_r[9:7];
   assign dac_code                 = dac_r;

   // conversion timing runs from pclk, never from the bus traffic
   conv_timer #(
      .CW   (`TMR_W),
      .C10  (`TMR_W'(CYC_10)),
      .C20  (`TMR_W'(CYC_20)),
      .C1K2 (`TMR_W'(CYC_1K2)),
      .C4K8 (`TMR_W'(CYC_4K8)),
      .C9K6 (`TMR_W'(CYC_9K6))
   ) u_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (ld),
      .rate    (ld_rate),
      .done    (tmr_done)
   );

   // results land in shadow words and publish together at sequence end
   result_bank #(
      .W (16),
      .N (`NUM_SLOTS)
   ) u_bank (
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (conv_end),
      .wr_idx  (slot_r),
      .wr_data (sat_code),
      .commit  (done_evt),
      .rd_idx  (res_idx),
      .rd_data (bank_rd)
   );
endmodule

// ---- testbench/adc_seq_chk_sva.sv ----
// checker: apb timing, ready pin, alert mask and steering relations
// assumes it is bound onto adc_conversion_sequencer and sees only its ports
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"
module adc_seq_chk (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic [7:0]  paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // steering and pins
   input wire logic [2:0]  conv_slot,
   input wire logic [2:0]  conv_rate,
   input wire logic        mains_reject,
   input wire logic        conv_active,
   input wire logic [13:0] dac_code,
   input wire logic        adc_rdy_n,
   input wire logic        alert_n
);
   // completed write, the moment a register takes the written value
   wire wr_done = psel & penable & pready & pwrite;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_wait;
      !pready ##1 pready;
   endsequence
   AST_WAIT_STATE: assert property (psel && $rose(penable) |-> s_wait ##1 !pready)
      else $error("apb answer timing wrong");
   AST_UNMAPPED: assert property (psel && penable && pready && paddr > `A_RES_LAST |-> pslverr)
      else $error("unmapped access not refused");
   AST_RDY_SET: assert property ($fell(adc_rdy_n) |-> $past(conv_active))
      else $error("ready asserted without a sequence");
   AST_RDY_REL: assert property (wr_done && (paddr == `A_CTRL ||
      (paddr == `A_LIVE && pwdata[0])) |=> adc_rdy_n) else $error("ready not released");
   AST_MASK: assert property (wr_done && paddr == `A_MASK && pwdata[0] |=> ##1 alert_n)
      else $error("masked flag still drives alert");
   AST_DAC_KEEP: assert property (wr_done && paddr == `A_FUNC |=> $stable(dac_code))
      else $error("dac code changed by function write");
   AST_MAINS: assert property (conv_active && $stable(conv_rate) |->
      mains_reject == (conv_rate < 3'h2)) else $error("mains rejection wrong for rate");
   AST_DIAG_RATE: assert property (conv_active && $past(conv_active) && conv_slot > 3'h2 &&
      $past(conv_slot) > 3'h1 |-> $stable(conv_rate)) else $error("diagnostic rate differs");
endmodule

bind adc_conversion_sequencer adc_seq_chk chk_u (.pclk, .presetn, .paddr, .psel, .penable,
   .pwrite, .pwdata, .pready, .pslverr, .conv_slot, .conv_rate, .mains_reject, .conv_active,
   .dac_code, .adc_rdy_n, .alert_n);

// ---- testbench/adc_front_model.sv ----
// front-end model: returns a slot-dependent code and range flags
// assumes steering from the sequencer on the same clock
`timescale 1ns/1ps
module adc_front_model (
   // clock and steering
   input  wire logic        pclk,
   input  wire logic [2:0]  conv_slot,
   input  wire logic        conv_active,
   // out-of-range requests from the bench
   input  wire logic        over_in,
   input  wire logic        under_in,
   // converter result
   output logic      [15:0] adc_code,
   output logic             adc_over,
   output logic             adc_under
);
   // idle shows a toggling pattern so a stale sample never looks right
   always_ff @(posedge pclk) begin
      adc_code  <= conv_active ? 16'h15A3 + {1'b0, conv_slot, 12'h000} : ~adc_code;
      adc_over  <= conv_active & over_in;
      adc_under <= conv_active & under_in;
   end
endmodule

// ---- testbench/testbench.sv ----
// testbench: apb host driving the sequencer against a front-end model
// assumes shortened conversion counts; function hold cut to FN_HOLD
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"
module testbench;
   localparam int FN_HOLD = 40; // the block does not time the hold, so it is shortened
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, over_in, under_in;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] adc_code;
   logic        adc_over, adc_under, mains_reject, conv_active, adc_powerdown, adc_rdy_n;
   logic        alert_n, aux_one_burnout_enable, aux_one_burnout_polarity;
   logic        aux_two_burnout_enable, aux_two_burnout_polarity;
   logic [2:0]  conv_slot, conv_range, conv_rate, aux_one_burnout_level, aux_two_burnout_level;
   logic [3:0]  conv_mux, buffer_standby;
   logic [13:0] dac_code;
   int          num_errors, compares;

   adc_conversion_sequencer #(.CYC_10(20), .CYC_20(12), .CYC_4K8(8),
      .CYC_9K6(6), .CYC_RDY(16)) dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .adc_code, .adc_over, .adc_under, .conv_slot,
      .conv_mux, .conv_range, .conv_rate, .mains_reject, .conv_active, .adc_powerdown,
      .buffer_standby, .aux_one_burnout_enable, .aux_one_burnout_polarity,
      .aux_one_burnout_level, .aux_two_burnout_enable, .aux_two_burnout_polarity,
      .aux_two_burnout_level, .dac_code, .adc_rdy_n, .alert_n);
   adc_front_model model_u (.pclk, .conv_slot, .conv_active, .over_in, .under_in, .adc_code,
      .adc_over, .adc_under);

   // 200 MHz clock
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one apb transfer; an idle edge first so no signal is set twice at one edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // first edge lets a just-written release land before looking
   task automatic wait_rdy();
      int n = 0;
      @(posedge pclk);
      while (adc_rdy_n !== 1'b0 && n++ < 500) @(posedge pclk);
      chk(32'(adc_rdy_n), 32'h0);
   endtask

   task automatic t_func();
      chk(32'(buffer_standby), 32'h0);
      apb(1'b1, `A_DAC, 32'h1234);
      for (int f = 5; f >= 0; f--) begin
         apb(1'b1, `A_FUNC, 32'(f));
         repeat (FN_HOLD) @(posedge pclk);
         apb(1'b0, `A_CFG, 32'h0);
         chk(rd & 32'hF, (f == 2 || f == 4 || f == 5) ? 32'h1 : 32'h0);
      end
      chk(32'(dac_code), 32'h1234);
      apb(1'b1, `A_DAC, 32'h0);
      apb(1'b1, `A_FUNC, 32'h1);
      repeat (FN_HOLD) @(posedge pclk);
      apb(1'b1, `A_DAC, 32'h2000);
      @(posedge pclk);
      chk(32'(dac_code), 32'h2000);
      apb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
   endtask

   task automatic t_single();
      apb(1'b1, `A_CFG, 32'h311241);
      apb(1'b1, `A_CTRL, 32'h213F);
      wait_rdy();
      chk(32'(conv_active), 32'h0);
      for (int s = 0; s < 6; s++) begin
         apb(1'b0, `A_RES1 + 8'(4 * s), 32'h0);
         chk(rd, 32'h15A3 + 32'(s << 12));
      end
      apb(1'b0, `A_CTRL, 32'h0);
      chk(rd, 32'h203F);
      apb(1'b1, `A_LIVE, 32'h1);
      @(posedge pclk);
      chk(32'(adc_rdy_n), 32'h1);
   endtask

   task automatic t_range();
      over_in <= 1'b1;
      apb(1'b1, `A_CTRL, 32'h0101);
      wait_rdy();
      apb(1'b0, `A_RES1, 32'h0);
      chk(rd, 32'hFFFF);
      chk(32'(alert_n), 32'h0);
      apb(1'b1, `A_ALERT, 32'h1);
      apb(1'b1, `A_MASK, 32'h1);
      over_in <= 1'b0;
      under_in <= 1'b1;
      apb(1'b1, `A_CTRL, 32'h0101);
      wait_rdy();
      apb(1'b0, `A_RES1, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, `A_ALERT, 32'h0);
      chk(rd, 32'h1);
      chk(32'(alert_n), 32'h1);
      under_in <= 1'b0;
   endtask

   // the host stops conversions before reconfiguring burnout and buffer standby
   task automatic t_cont();
      apb(1'b1, `A_CFG, 32'h311201);
      apb(1'b1, `A_CTRL, 32'h0201);
      apb(1'b0, `A_RES1, 32'h0);
      chk(rd, 32'h0);
      wait_rdy();
      repeat (18) @(posedge pclk);
      chk(32'(adc_rdy_n), 32'h1);
      wait_rdy();
      apb(1'b1, `A_CTRL, 32'h0001);
      chk(32'(conv_active), 32'h1);
      chk(32'({conv_mux, conv_range, conv_rate, mains_reject}), 32'hA1);
      wait_rdy();
      repeat (40) @(posedge pclk);
      chk(32'(conv_active), 32'h0);
      apb(1'b1, `A_CTRL, 32'h0300);
      apb(1'b1, `A_BURN, 32'h231);
      apb(1'b1, `A_STBY, 32'hA);
      @(posedge pclk);
      chk(32'({aux_two_burnout_level, aux_two_burnout_polarity, aux_two_burnout_enable,
         aux_one_burnout_level, aux_one_burnout_polarity, aux_one_burnout_enable}), 32'h231);
      chk(32'(buffer_standby), 32'hA);
      chk(32'(adc_powerdown), 32'h1);
   endtask

   task automatic end_sim();
      $display("num_errors=%0d compares=%0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // watchdog: the whole run needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      end_sim();
   end

   // main sequence
   initial begin
      {presetn, psel, penable, pwrite, over_in, under_in, paddr, pwdata} = '0;
      num_errors = 0;
      compares = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_func();
      t_single();
      t_range();
      t_cont();
      end_sim();
   end
endmodule
